// >>> adc_cal_defines.vh
`ifndef ADC_CAL_DEFINES_VH
`define ADC_CAL_DEFINES_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFS_MODE        8'h00
`define OFS_CONFIG      8'h04
`define OFS_STATUS      8'h08
`define OFS_DATA        8'h0C
`define OFS_OFFSET      8'h10
`define OFS_FULLSCALE   8'h14
`define OFS_IRQ_STATUS  8'h18
`define OFS_IRQ_MASK    8'h1C

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CFG_CHAN_LSB    0
`define CFG_GAIN_LSB    8
`define STAT_READY_BIT  0
`define STAT_BUSY_BIT   1
`define IRQ_CAL_BIT     0
`define IRQ_CONV_BIT    1

// ----------------------------------------------------------------------
// Operating modes
// ----------------------------------------------------------------------
`define MODE_CONT       3'h0
`define MODE_SINGLE     3'h1
`define MODE_IDLE       3'h2
`define MODE_PDOWN      3'h3
`define MODE_INT_ZERO   3'h4
`define MODE_INT_FULL   3'h5
`define MODE_SYS_ZERO   3'h6
`define MODE_SYS_FULL   3'h7

// ----------------------------------------------------------------------
// Input routing codes and special values
// ----------------------------------------------------------------------
`define ROUTE_EXT       2'h0
`define ROUTE_ZERO      2'h1
`define ROUTE_FULL      2'h2
`define ROUTE_SUPPLY    2'h3
`define CHAN_SUPPLY     3'h7
`define GAIN_ONE        3'h0

// ----------------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------------
`define RST_MODE        3'h2
`define RST_OFFSET      24'h80_0000
`define RST_FULLSCALE   24'h80_0000
`define CONV_EDGES_DEF  16
`define CYC_ZERO        3'h2
`define CYC_FULL_G1     3'h2
`define CYC_FULL_GN     3'h4
`define CYC_SYS_FULL    3'h2
`define CYC_CONV        3'h1

`endif

// >>> cal_scaler.v
`timescale 1ns/1ps
`default_nettype none

module cal_scaler #(
    parameter W = 24
) (
    // Clock and reset
    input  wire         aclk,
    input  wire         aresetn,
    // Operands
    input  wire         go,
    input  wire [W-1:0] raw,
    input  wire [W-1:0] offset,
    input  wire [W-1:0] fullscale,
    // Results
    output reg          valid,
    output reg  [W-1:0] result,
    output reg  [W-1:0] fs_new
);

    wire signed [W:0]     diff;
    wire signed [2*W+1:0] prod;
    wire signed [W+2:0]   scaled;
    wire signed [W+2:0]   fs_calc;

    assign diff    = $signed({1'b0, raw}) - $signed({1'b0, offset});
    assign prod    = diff * $signed({1'b0, fullscale});
    assign scaled  = prod[2*W+1:W-1] + $signed({3'b000, 1'b1, {(W-1){1'b0}}});
    // The reciprocal is taken as 2 - x around unity to avoid a divider.
    assign fs_calc = $signed({2'b01, {W{1'b0}}}) - $signed({{2{diff[W]}}, diff});

    function [W-1:0] sat;
        input signed [W+2:0] v;
        begin
            if (v < 0)
                sat = {W{1'b0}};
            else if (v > $signed({3'b000, {W{1'b1}}}))
                sat = {W{1'b1}};
            else
                sat = v[W-1:0];
        end
    endfunction

    always @(posedge aclk) begin
        if (!aresetn) begin
            valid  <= 1'b0;
            result <= {W{1'b0}};
            fs_new <= {W{1'b0}};
        end else begin
            valid <= go;
            if (go) begin
                result <= sat(scaled);
                fs_new <= sat(fs_calc);
            end
        end
    end

endmodule
`default_nettype wire

// >>> adc_calibration_sequencer.v
// Behaviour
// - Channel select all ones converts supply divided by 6 against internal ref.
// - Mode field offers internal and system zero-scale and full-scale calibration.
// - Each result has offset subtracted, then multiplied by full-scale coefficient.
// - Calibration end updates coefficient, sets ready, drops pin, returns idle.
// - Internal calibrations route internal zero or full-scale source to input.
// - Internal and system offset calibrations take two conversion cycles.
// - Internal full-scale takes 2 cycles at gain 1, else 4.
// - Ready pin goes high at calibration start, low at completion.
// - New full-scale coefficient stored for the currently selected channel.
// - System full-scale takes 2 cycles at any gain and rate.
`include "adc_cal_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module adc_calibration_sequencer #(
    parameter W          = 24,
    parameter CONV_EDGES = `CONV_EDGES_DEF
) (
    // Clock and reset
    input  wire         aclk,
    input  wire         aresetn,
    // AXI4-Lite write address
    input  wire [7:0]   awaddr,
    input  wire         awvalid,
    output reg          awready,
    // AXI4-Lite write data
    input  wire [31:0]  wdata,
    input  wire [3:0]   wstrb,
    input  wire         wvalid,
    output reg          wready,
    // AXI4-Lite write response
    output reg  [1:0]   bresp,
    output reg          bvalid,
    input  wire         bready,
    // AXI4-Lite read address
    input  wire [7:0]   araddr,
    input  wire         arvalid,
    output reg          arready,
    // AXI4-Lite read data
    output reg  [31:0]  rdata,
    output reg  [1:0]   rresp,
    output reg          rvalid,
    input  wire         rready,
    // Modulator side
    input  wire         mod_clk,
    input  wire [W-1:0] raw_result,
    output reg  [1:0]   input_route,
    output reg          internal_ref,
    // Serial port pins
    input  wire         cs_n,
    output reg          dout_rdy,
    output reg          dout_oe_n,
    // Interrupt
    output reg          irq
);

    // ------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------
    localparam [2:0] ST_IDLE  = 3'b001;
    localparam [2:0] ST_RUN   = 3'b010;
    localparam [2:0] ST_SCALE = 3'b100;

    // ------------------------------------------------------------------
    // Registers and signals
    // ------------------------------------------------------------------
    reg  [2:0]   mode_reg;
    reg  [2:0]   chan_reg;
    reg  [2:0]   gain_reg;
    reg          ready_reg;
    reg  [W-1:0] data_reg;
    reg  [1:0]   irq_stat_reg;
    reg  [1:0]   irq_mask_reg;
    reg  [W-1:0] off_mem [0:7];
    reg  [W-1:0] fs_mem  [0:7];
    reg  [2:0]   state_reg;
    reg  [2:0]   cyc_reg;
    reg  [15:0]  edge_reg;
    reg          aw_held;
    reg          w_held;
    reg  [7:0]   aw_addr_reg;
    reg  [31:0]  w_data_reg;
    reg  [3:0]   w_strb_reg;
    reg          mclk_s1;
    reg          mclk_s2;
    reg          mclk_s3;
    reg  [W-1:0] raw_s1;
    reg  [W-1:0] raw_s2;
    reg          cs_s1;
    reg          cs_s2;
    reg          scale_go;
    reg  [31:0]  rd_next;
    reg          rd_ok;
    reg  [2:0]   cyc_next;
    reg  [1:0]   route_next;
    integer      i;

    wire         wr_do;
    wire         rd_do;
    wire         wr_ok;
    wire         start;
    wire         mod_edge;
    wire         cyc_end;
    wire         is_cal;
    wire         sc_valid;
    wire [W-1:0] sc_result;
    wire [W-1:0] sc_fs;
    wire [31:0]  off_wr;
    wire [31:0]  fs_wr;
    wire [W-1:0] off_sel;
    wire [W-1:0] fs_sel;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  strb;
        integer b;
        begin
            merge = old;
            for (b = 0; b < 4; b = b + 1) begin
                if (strb[b])
                    merge[8*b +: 8] = nw[8*b +: 8];
            end
        end
    endfunction

    function mapped;
        input [7:0] a;
        begin
            mapped = (a[1:0] == 2'b00) && (a <= `OFS_IRQ_MASK);
        end
    endfunction

    // ------------------------------------------------------------------
    // Synchronisers for pins from outside the clock domain
    // ------------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            mclk_s1 <= 1'b0;
            mclk_s2 <= 1'b0;
            mclk_s3 <= 1'b0;
            raw_s1  <= {W{1'b0}};
            raw_s2  <= {W{1'b0}};
            cs_s1   <= 1'b1;
            cs_s2   <= 1'b1;
        end else begin
            mclk_s1 <= mod_clk;
            mclk_s2 <= mclk_s1;
            mclk_s3 <= mclk_s2;
            raw_s1  <= raw_result;
            raw_s2  <= raw_s1;
            cs_s1   <= cs_n;
            cs_s2   <= cs_s1;
        end
    end

    assign mod_edge = mclk_s2 && !mclk_s3;

    // ------------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------------
    assign wr_do   = aw_held && w_held && !bvalid;
    assign rd_do   = arvalid && arready;
    assign wr_ok   = mapped(aw_addr_reg);
    assign off_wr  = merge({{(32-W){1'b0}}, off_sel}, w_data_reg, w_strb_reg);
    assign fs_wr   = merge({{(32-W){1'b0}}, fs_sel}, w_data_reg, w_strb_reg);
    assign start   = wr_do && wr_ok && (aw_addr_reg == `OFS_MODE) &&
                     w_strb_reg[0] && (w_data_reg[2:0] != `MODE_IDLE) &&
                     (w_data_reg[2:0] != `MODE_PDOWN);
    assign off_sel = off_mem[chan_reg];
    assign fs_sel  = fs_mem[chan_reg];

    always @(posedge aclk) begin
        if (!aresetn) begin
            awready     <= 1'b0;
            wready      <= 1'b0;
            bvalid      <= 1'b0;
            bresp       <= 2'b00;
            arready     <= 1'b0;
            rvalid      <= 1'b0;
            rresp       <= 2'b00;
            rdata       <= 32'h0000_0000;
            aw_held     <= 1'b0;
            w_held      <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg  <= 32'h0000_0000;
            w_strb_reg  <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                awready     <= 1'b0;
                aw_held     <= 1'b1;
                aw_addr_reg <= awaddr;
            end else if (!aw_held && !bvalid) begin
                awready <= 1'b1;
            end
            if (wvalid && wready) begin
                wready     <= 1'b0;
                w_held     <= 1'b1;
                w_data_reg <= wdata;
                w_strb_reg <= wstrb;
            end else if (!w_held && !bvalid) begin
                wready <= 1'b1;
            end
            if (wr_do) begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
                bvalid  <= 1'b1;
                bresp   <= wr_ok ? 2'b00 : 2'b10;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
            if (rd_do) begin
                arready <= 1'b0;
                rvalid  <= 1'b1;
                rdata   <= rd_next;
                rresp   <= rd_ok ? 2'b00 : 2'b10;
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end else if (!rvalid) begin
                arready <= 1'b1;
            end
        end
    end

    always @* begin
        rd_next = 32'h0000_0000;
        rd_ok   = mapped(araddr);
        case (araddr)
            `OFS_MODE:       rd_next[2:0] = mode_reg;
            `OFS_CONFIG: begin
                rd_next[`CFG_CHAN_LSB +: 3] = chan_reg;
                rd_next[`CFG_GAIN_LSB +: 3] = gain_reg;
            end
            `OFS_STATUS: begin
                rd_next[`STAT_READY_BIT] = ready_reg;
                rd_next[`STAT_BUSY_BIT]  = (state_reg != ST_IDLE);
            end
            `OFS_DATA:       rd_next[W-1:0] = data_reg;
            `OFS_OFFSET:     rd_next[W-1:0] = off_sel;
            `OFS_FULLSCALE:  rd_next[W-1:0] = fs_sel;
            `OFS_IRQ_STATUS: rd_next[1:0]   = irq_stat_reg;
            `OFS_IRQ_MASK:   rd_next[1:0]   = irq_mask_reg;
            default:         rd_next = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------------
    // Calibration length and input routing
    // ------------------------------------------------------------------
    always @* begin
        case (w_data_reg[2:0])
            `MODE_INT_ZERO: cyc_next = `CYC_ZERO;
            `MODE_SYS_ZERO: cyc_next = `CYC_ZERO;
            `MODE_INT_FULL: cyc_next = (gain_reg == `GAIN_ONE) ?
                                       `CYC_FULL_G1 : `CYC_FULL_GN;
            `MODE_SYS_FULL: cyc_next = `CYC_SYS_FULL;
            default:        cyc_next = `CYC_CONV;
        endcase
    end

    always @* begin
        if (state_reg == ST_RUN && mode_reg == `MODE_INT_ZERO)
            route_next = `ROUTE_ZERO;
        else if (state_reg == ST_RUN && mode_reg == `MODE_INT_FULL)
            route_next = `ROUTE_FULL;
        else if (chan_reg == `CHAN_SUPPLY)
            route_next = `ROUTE_SUPPLY;
        else
            route_next = `ROUTE_EXT;
    end

    // ------------------------------------------------------------------
    // Conversion and calibration sequencer
    // ------------------------------------------------------------------
    assign is_cal  = mode_reg[2];
    assign cyc_end = (state_reg == ST_RUN) && mod_edge &&
                     (edge_reg == CONV_EDGES - 1);

    always @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= ST_IDLE;
            mode_reg  <= `RST_MODE;
            cyc_reg   <= 3'h0;
            edge_reg  <= 16'h0000;
            scale_go  <= 1'b0;
        end else begin
            scale_go <= 1'b0;
            if (start) begin
                mode_reg  <= w_data_reg[2:0];
                state_reg <= ST_RUN;
                cyc_reg   <= cyc_next;
                edge_reg  <= 16'h0000;
            end else if (wr_do && wr_ok && aw_addr_reg == `OFS_MODE &&
                         w_strb_reg[0]) begin
                mode_reg  <= w_data_reg[2:0];
                state_reg <= ST_IDLE;
            end else begin
                case (state_reg)
                    ST_IDLE: state_reg <= ST_IDLE;
                    ST_RUN: begin
                        if (mod_edge)
                            edge_reg <= cyc_end ? 16'h0000 :
                                        edge_reg + 16'h0001;
                        if (cyc_end) begin
                            if (cyc_reg == 3'h1) begin
                                scale_go  <= 1'b1;
                                state_reg <= ST_SCALE;
                            end else begin
                                cyc_reg <= cyc_reg - 3'h1;
                            end
                        end
                    end
                    ST_SCALE: begin
                        if (sc_valid) begin
                            if (mode_reg == `MODE_CONT) begin
                                state_reg <= ST_RUN;
                                cyc_reg   <= `CYC_CONV;
                            end else begin
                                state_reg <= ST_IDLE;
                                mode_reg  <= `MODE_IDLE;
                            end
                        end
                    end
                    default: state_reg <= ST_IDLE;
                endcase
            end
        end
    end

    cal_scaler #(
        .W         (W)
    ) scaler (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .go        (scale_go),
        .raw       (raw_s2),
        .offset    (off_sel),
        .fullscale (fs_sel),
        .valid     (sc_valid),
        .result    (sc_result),
        .fs_new    (sc_fs)
    );

    // ------------------------------------------------------------------
    // Configuration, coefficients, data and status
    // ------------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            chan_reg  <= 3'h0;
            gain_reg  <= `GAIN_ONE;
            data_reg  <= {W{1'b0}};
            ready_reg <= 1'b0;
            for (i = 0; i < 8; i = i + 1) begin
                off_mem[i] <= `RST_OFFSET;
                fs_mem[i]  <= `RST_FULLSCALE;
            end
        end else begin
            if (wr_do && wr_ok) begin
                case (aw_addr_reg)
                    `OFS_CONFIG: begin
                        if (w_strb_reg[0])
                            chan_reg <= w_data_reg[`CFG_CHAN_LSB +: 3];
                        if (w_strb_reg[1])
                            gain_reg <= w_data_reg[`CFG_GAIN_LSB +: 3];
                    end
                    `OFS_OFFSET:    off_mem[chan_reg] <= off_wr[W-1:0];
                    `OFS_FULLSCALE: fs_mem[chan_reg]  <= fs_wr[W-1:0];
                    default: ;
                endcase
            end
            // A finished result outranks a data read in the same cycle.
            if (start)
                ready_reg <= 1'b0;
            else if (sc_valid && state_reg == ST_SCALE)
                ready_reg <= 1'b1;
            else if (rd_do && araddr == `OFS_DATA)
                ready_reg <= 1'b0;
            if (sc_valid && state_reg == ST_SCALE && !start) begin
                case (mode_reg)
                    `MODE_INT_ZERO: off_mem[chan_reg] <= raw_s2;
                    `MODE_SYS_ZERO: off_mem[chan_reg] <= raw_s2;
                    `MODE_INT_FULL: fs_mem[chan_reg]  <= sc_fs;
                    `MODE_SYS_FULL: fs_mem[chan_reg]  <= sc_fs;
                    default:        data_reg <= sc_result;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Pins, routing and interrupt
    // ------------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            dout_rdy     <= 1'b1;
            dout_oe_n    <= 1'b1;
            input_route  <= `ROUTE_EXT;
            internal_ref <= 1'b0;
            irq_stat_reg <= 2'b00;
            irq_mask_reg <= 2'b00;
            irq          <= 1'b0;
        end else begin
            input_route  <= route_next;
            internal_ref <= (chan_reg == `CHAN_SUPPLY);
            // The pin only drives while the host holds chip select low.
            dout_oe_n    <= cs_s2;
            if (start)
                dout_rdy <= 1'b1;
            else if (sc_valid && state_reg == ST_SCALE)
                dout_rdy <= 1'b0;
            if (wr_do && wr_ok && aw_addr_reg == `OFS_IRQ_MASK &&
                w_strb_reg[0])
                irq_mask_reg <= w_data_reg[1:0];
            // Set wins over a write-one-to-clear in the same cycle.
            irq_stat_reg <= (irq_stat_reg &
                ~((wr_do && wr_ok && aw_addr_reg == `OFS_IRQ_STATUS &&
                   w_strb_reg[0]) ? w_data_reg[1:0] : 2'b00)) |
                {(sc_valid && state_reg == ST_SCALE && !is_cal),
                 (sc_valid && state_reg == ST_SCALE && is_cal)};
            irq <= |(irq_stat_reg & irq_mask_reg);
        end
    end

endmodule
`default_nettype wire

// >>> adc_cal_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_cal_defines.vh"
module adc_cal_monitor (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Bus handshakes
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic [31:0] rdata,
    // Converter and pin side
    input wire logic [1:0]  input_route,
    input wire logic        internal_ref,
    input wire logic        dout_rdy
);
    // --------------------------------
    // Checks
    // --------------------------------
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    b_hold_a: assert property (bvalid && !bready |=> bvalid)
        else $error("bvalid dropped");
    b_clear_a: assert property (bvalid && bready |=> !bvalid)
        else $error("bvalid repeated");
    aw_block_a: assert property (awvalid && awready |=> !awready)
        else $error("awready held high");
    r_answer_a: assert property (arvalid && arready |=> rvalid && !arready)
        else $error("read answer late");
    r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("rdata changed");
    supply_ref_a: assert property (
        input_route == `ROUTE_SUPPLY |-> internal_ref)
        else $error("supply without internal ref");
    pin_rise_a: assert property (
        $rose(dout_rdy) |-> bvalid || $past(bvalid))
        else $error("pin rose without write");
    cal_end_route_a: assert property (
        $fell(dout_rdy) |-> input_route inside {`ROUTE_EXT, `ROUTE_SUPPLY})
        else $error("internal source routed at end");
    cover property ($fell(dout_rdy));
    cover property (input_route == `ROUTE_FULL);
    cover property (input_route == `ROUTE_SUPPLY);
endmodule
bind adc_calibration_sequencer adc_cal_monitor adc_cal_monitor_i (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready),
    .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .input_route(input_route), .internal_ref(internal_ref),
    .dout_rdy(dout_rdy));
`default_nettype wire

// >>> adc_modulator_model.sv
`timescale 1ns/1ps
`default_nettype none
module adc_modulator_model (
    // Control
    input  wire logic        run,
    input  wire logic [23:0] code,
    // Converter side
    output logic             mod_clk,
    output logic [23:0]      raw_result
);
    // --------------------------------
    // Gated converter clock, off phase to aclk
    // --------------------------------
    initial begin
        mod_clk = 1'b0;
        #13;
        forever #200 mod_clk = run ? ~mod_clk : 1'b0;
    end
    assign raw_result = code;
endmodule
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_cal_defines.vh"
`define CHK(nm, e, s) begin num_checks++; if ((s) !== (e)) begin \
    mismatches++; $display("[FAIL] %s expected %h seen %h", nm, e, s); \
    end end
module testbench;
    localparam int CE = 2;
    logic        aclk = 0, aresetn = 0, cs_n = 0, run = 0;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
    logic        rready = 0, awready, wready, bvalid, arready, rvalid;
    logic        mod_clk, internal_ref, dout_rdy, dout_oe_n, irq;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, rd;
    logic [23:0] code = 0, raw_result;
    logic [1:0]  bresp, rresp, input_route, rs, rt;
    int          mismatches = 0, num_checks = 0, edges = 0, n;
    always #25 aclk = ~aclk;
    always @(posedge mod_clk) edges++;
    adc_modulator_model adc_modulator_model_i (.run(run), .code(code),
        .mod_clk(mod_clk), .raw_result(raw_result));
    adc_calibration_sequencer #(.W(24), .CONV_EDGES(CE))
        adc_calibration_sequencer_i (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .mod_clk(mod_clk), .raw_result(raw_result),
        .input_route(input_route), .internal_ref(internal_ref),
        .cs_n(cs_n), .dout_rdy(dout_rdy), .dout_oe_n(dout_oe_n), .irq(irq));
    // --------------------------------
    // Shared tasks
    // --------------------------------
    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic bound(input int i, input int lim);
        if (i >= lim) begin
            mismatches++;
            conclude();
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        int i;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        rs = bresp;
        bready <= 1'b0;
        bound(i, 100);
        @(posedge aclk);
    endtask
    task automatic axr(input logic [7:0] a);
        int i;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
        bound(i, 100);
        @(posedge aclk);
    endtask
    // The clock runs only while run is high, so edges counts cycles.
    task automatic run_cal(input logic [2:0] m);
        int i;
        edges = 0;
        axw(`OFS_MODE, {29'h0, m});
        #1 rt = input_route;
        run <= 1'b1;
        for (i = 0; i < 4000; i++) begin
            @(posedge aclk);
            if (dout_rdy === 1'b0) break;
        end
        bound(i, 4000);
        run <= 1'b0;
        n = edges;
    endtask
    // --------------------------------
    // Scenarios
    // --------------------------------
    task automatic sc_reset;
        axr(`OFS_MODE);
        `CHK("mode", 32'h0000_0002, rd)
        axr(`OFS_OFFSET);
        `CHK("offset", 32'h0080_0000, rd)
        axr(8'h40);
        `CHK("rresp", 2'b10, rs)
        axw(8'h22, 32'h0000_0000);
        `CHK("bresp", 2'b10, rs)
    endtask
    task automatic sc_int_zero;
        axw(`OFS_IRQ_MASK, 32'h0000_0001);
        code <= 24'h12_3456;
        run_cal(`MODE_INT_ZERO);
        `CHK("edges", 2 * CE, n)
        `CHK("route", `ROUTE_ZERO, rt)
        `CHK("pin", 1'b0, dout_oe_n)
        @(posedge aclk);
        `CHK("irq", 1'b1, irq)
        axr(`OFS_OFFSET);
        `CHK("offset", 32'h0012_3456, rd)
        axr(`OFS_STATUS);
        `CHK("ready", 1'b1, rd[0])
        axr(`OFS_MODE);
        `CHK("mode", {29'h0, `MODE_IDLE}, rd)
        axw(`OFS_IRQ_STATUS, 32'h0000_0001);
        `CHK("irq", 1'b0, irq)
    endtask
    task automatic sc_int_full;
        axw(`OFS_IRQ_MASK, 32'h0000_0000);
        axw(`OFS_CONFIG, 32'h0000_0001);
        code <= 24'hC0_0000;
        run_cal(`MODE_INT_FULL);
        `CHK("edges", 2 * CE, n)
        `CHK("route", `ROUTE_FULL, rt)
        axr(`OFS_FULLSCALE);
        `CHK("fs", 32'h00C0_0000, rd)
        `CHK("masked irq", 1'b0, irq)
        axw(`OFS_CONFIG, 32'h0000_0101);
        run_cal(`MODE_INT_FULL);
        `CHK("edges", 4 * CE, n)
        axw(`OFS_CONFIG, 32'h0000_0000);
        axr(`OFS_FULLSCALE);
        `CHK("fs", 32'h0080_0000, rd)
        axw(`OFS_IRQ_STATUS, 32'h0000_0003);
    endtask
    task automatic sc_sys;
        axw(`OFS_CONFIG, 32'h0000_0702);
        code <= 24'h10_0000;
        run_cal(`MODE_SYS_ZERO);
        `CHK("edges", 2 * CE, n)
        `CHK("route", `ROUTE_EXT, rt)
        code <= 24'h50_0000;
        run_cal(`MODE_SYS_FULL);
        `CHK("edges", 2 * CE, n)
        axr(`OFS_FULLSCALE);
        `CHK("fs", 32'h00C0_0000, rd)
    endtask
    task automatic sc_conv;
        axw(`OFS_CONFIG, 32'h0000_0003);
        axw(`OFS_OFFSET, 32'h0080_0000);
        axw(`OFS_FULLSCALE, 32'h0040_0000);
        code <= 24'hC0_0000;
        run_cal(`MODE_SINGLE);
        `CHK("edges", CE, n)
        axr(`OFS_DATA);
        `CHK("data", 32'h00A0_0000, rd)
    endtask
    task automatic sc_supply;
        axw(`OFS_CONFIG, 32'h0000_0007);
        @(posedge aclk);
        `CHK("ref", 1'b1, internal_ref)
        `CHK("route", `ROUTE_SUPPLY, input_route)
        axw(`OFS_CONFIG, 32'h0000_0000);
    endtask
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        sc_reset();
        sc_int_zero();
        sc_int_full();
        sc_sys();
        sc_conv();
        sc_supply();
        conclude();
    end
endmodule
`default_nettype wire
